// ==== hdl/fbs_sram.sv ====
`timescale 1ns/1ns
// Functional notes
// RQ1: All synchronous inputs are captured on the rising clock edge.
// RQ2: Either strobe starts an access; processor strobe ignored while chip_sel1_n high.
// RQ3: Read starts with all selects active and a strobe low.
// RQ4: Read start latches address into address register and burst counter.
// RQ5: Read data drives only with output enable low, flowing through without pipeline.
// RQ6: Processor start ignores write inputs; writes happen on following edges.
// RQ7: Controller write needs selects, processor strobe high, write inputs active.
// RQ8: Controller write loads address and stores data captured that same edge.
// RQ9: Outputs go high impedance once a write is detected, ignoring output enable.
// RQ10: Master raises output enable and releases bus before driving write data; the bench raises it on the same edge that it drives the data.
// RQ11: Byte writes store only lanes selected, each lane with its parity bit.
// RQ12: Global write stores all four lanes, overriding byte enables.
// RQ13: Two-bit wraparound burst counter loads from lowest address bits.
// RQ14: Burst counter steps only when burst_advance_n is low at an edge.
// RQ15: Mode low selects linear order, high selects interleaved order.
// RQ16: Interleaved order follows start xor beat number.
// RQ17: Linear order increments modulo four from start value.
// RQ18: Sleep request enters sleep in two cycles, exits in two, keeps data.
// RQ19: Accesses pending on sleep entry are dropped.
// RQ20: Master deselects the device before raising sleep_request; the bench deselects on the same edge that it raises it.
// RQ21: Master keeps selects and strobes inactive two clocks after sleep ends.
// RQ22: With both strobes low, only the processor strobe is acted upon; with chip_sel1_n high the code takes the controller strobe instead.
// RQ23: First read clock after deselect keeps outputs tristated.
// RQ24: Write when global_write_n low, or byte enable with any lane selected.
// RQ25: No strobe and no advance suspends the burst at the current address.
module fbs_sram #(
	parameter int ADDR_W = fbs_pkg::ADDR_W_DEFAULT,
	parameter int LANES = fbs_pkg::LANES_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Address and selects
	input wire logic [ADDR_W-1:0] addr,
	input wire logic chip_sel1_n,
	input wire logic chip_sel2,
	input wire logic chip_sel3_n,
	// Burst control
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	// Write control
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [LANES-1:0] byte_lane_select_n,
	// Data and parity pins
	input wire logic [LANES*fbs_pkg::LANE_DATA_W-1:0] data_in,
	output logic [LANES*fbs_pkg::LANE_DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES-1:0] parity_out,
	output logic parity_oe_n,
	// Asynchronous and static pins
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic mode,
	// Status
	output logic sleep_active
);
	localparam int HI_W = ADDR_W - fbs_pkg::BURST_W;
	localparam int DEPTH = 2 ** ADDR_W;

	if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_addr
		$error("ADDR_W out of range");
	end
	if (LANES < 1) begin : g_bad_lanes
		$error("LANES must be at least one");
	end

	// Two-stage synchronisers for pins from outside the clock
	logic oe_meta;
	logic oe_sync_n;
	logic sleep_meta;
	logic sleep_sync;
	logic mode_meta;
	logic mode_sync;

	always_ff @(posedge clk) begin
		if (rst) begin
			oe_meta <= 1'b1;
			oe_sync_n <= 1'b1;
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
			mode_meta <= 1'b1;
			mode_sync <= 1'b1;
		end else begin
			oe_meta <= output_enable_n;
			oe_sync_n <= oe_meta;
			sleep_meta <= sleep_request;
			sleep_sync <= sleep_meta;
			mode_meta <= mode;
			mode_sync <= mode_meta;
		end
	end

	// Sleep sequencing
	fbs_pkg::fbs_sleep_t sleep_state;
	logic [1:0] sleep_cnt;
	logic awake;

	assign awake = (sleep_state == fbs_pkg::FBS_RUN);
	assign sleep_active = (sleep_state == fbs_pkg::FBS_SLEEP);

	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_state <= fbs_pkg::FBS_RUN;
			sleep_cnt <= 2'h0;
		end else begin
			unique case (sleep_state)
				fbs_pkg::FBS_RUN: begin
					sleep_cnt <= 2'h0;
					if (sleep_sync)
						sleep_state <= fbs_pkg::FBS_ENTER;
				end
				fbs_pkg::FBS_ENTER: begin
					sleep_cnt <= sleep_cnt + 2'h1;
					if (sleep_cnt == fbs_pkg::SLEEP_CNT_LAST) begin // [RQ18]
						sleep_state <= fbs_pkg::FBS_SLEEP;
						sleep_cnt <= 2'h0;
					end
				end
				fbs_pkg::FBS_SLEEP: begin
					sleep_cnt <= 2'h0;
					if (!sleep_sync)
						sleep_state <= fbs_pkg::FBS_EXIT;
				end
				fbs_pkg::FBS_EXIT: begin
					sleep_cnt <= sleep_cnt + 2'h1;
					if (sleep_cnt == fbs_pkg::SLEEP_CNT_LAST) begin // [RQ18]
						sleep_state <= fbs_pkg::FBS_RUN;
						sleep_cnt <= 2'h0;
					end
				end
			endcase
		end
	end

	// Cycle decode from the pins as they stand before the edge
	logic ce_ok;
	logic wr_req;
	logic proc_take;
	logic ctrl_take;
	logic start;
	logic rd_start;
	logic wr_start;
	logic cont;
	logic advance_now;
	logic write_now;
	logic load;

	assign ce_ok = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	assign wr_req = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n)); // [RQ24]
	assign proc_take = awake && !processor_addr_strobe_n && !chip_sel1_n; // [RQ2]
	assign ctrl_take = awake && !controller_addr_strobe_n && !proc_take; // [RQ7] [RQ22]
	assign start = proc_take || ctrl_take;
	assign rd_start = start && ce_ok && (proc_take || !wr_req); // [RQ3] [RQ6]
	assign wr_start = ctrl_take && ce_ok && wr_req; // [RQ7]
	assign load = rd_start || wr_start;

	// Burst state
	logic active;
	logic wr_cyc;
	logic read_mask;

	assign cont = awake && !start && active;
	assign advance_now = cont && !burst_advance_n; // [RQ14] [RQ25]
	assign write_now = wr_start || (cont && wr_req); // [RQ6]

	always_ff @(posedge clk) begin
		if (rst) begin
			active <= 1'b0;
		end else if (!awake) begin
			active <= 1'b0; // [RQ19]
		end else if (start) begin
			active <= ce_ok;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_cyc <= 1'b0;
			read_mask <= 1'b0;
		end else begin
			wr_cyc <= write_now;
			read_mask <= rd_start && !active; // [RQ23]
		end
	end

	// Address register and burst counter
	logic [HI_W-1:0] addr_hi;
	logic [1:0] burst_low;
	logic [1:0] next_burst_low;

	always_ff @(posedge clk) begin
		if (rst)
			addr_hi <= '0;
		else if (load)
			addr_hi <= addr[ADDR_W-1:fbs_pkg::BURST_W]; // [RQ1] [RQ4] [RQ8]
	end

	fbs_burst_counter u_burst (
		.clk(clk),
		.rst(rst),
		.load(load),
		.load_val(addr[1:0]),
		.advance(advance_now),
		.interleaved(mode_sync != fbs_pkg::MODE_LINEAR), // [RQ15]
		.count(burst_low),
		.next_count(next_burst_low)
	);

	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_addr;

	assign wr_addr = {(load ? addr[ADDR_W-1:fbs_pkg::BURST_W] : addr_hi), next_burst_low};
	assign rd_addr = {addr_hi, burst_low};

	// Per-lane storage, each lane a data byte and its parity bit
	logic [LANES-1:0] lane_we;

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [fbs_pkg::LANE_W-1:0] lane_mem [0:DEPTH-1];
		logic [fbs_pkg::LANE_W-1:0] rd_word;

		assign lane_we[i] = write_now &&
			(!global_write_n || (!byte_write_enable_n && !byte_lane_select_n[i])); // [RQ11] [RQ12]

		always_ff @(posedge clk) begin
			if (lane_we[i])
				lane_mem[wr_addr] <= {parity_in[i],
					data_in[i*fbs_pkg::LANE_DATA_W +: fbs_pkg::LANE_DATA_W]}; // [RQ1] [RQ8]
		end

		// Flow-through read straight from the array
		assign rd_word = lane_mem[rd_addr]; // [RQ5]
		assign data_out[i*fbs_pkg::LANE_DATA_W +: fbs_pkg::LANE_DATA_W] =
			rd_word[fbs_pkg::LANE_DATA_W-1:0];
		assign parity_out[i] = rd_word[fbs_pkg::LANE_DATA_W];
	end

	// Pin drive: a write seen on the pins also releases the bus at once
	logic drive;

	assign drive = awake && active && !wr_cyc && !read_mask && !wr_req &&
		!oe_sync_n; // [RQ5] [RQ9] [RQ23]
	assign data_oe_n = !drive;
	assign parity_oe_n = !drive;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence enter_seq;
		sleep_state == fbs_pkg::FBS_ENTER [*2];
	endsequence

	sequence exit_seq;
		sleep_state == fbs_pkg::FBS_EXIT [*2];
	endsequence

	proc_read_start_a: assert property ( // [RQ6]
		proc_take && ce_ok |=> active && !wr_cyc && rd_addr == $past(addr))
		else $error("processor start did not begin a read");
	ctrl_ignored_a: assert property ( // [RQ22]
		proc_take && !controller_addr_strobe_n && wr_req |=> !wr_cyc)
		else $error("controller strobe honoured beside processor strobe");
	ctrl_write_a: assert property ( // [RQ8]
		wr_start && !global_write_n |=> wr_cyc && rd_addr == $past(addr) &&
			data_out == $past(data_in) && parity_out == $past(parity_in))
		else $error("controller write did not store the data");
	write_tristate_a: assert property ( // [RQ9]
		wr_cyc || (active && wr_req && awake) |-> data_oe_n && parity_oe_n)
		else $error("outputs driven during a write");
	first_read_mask_a: assert property ( // [RQ23]
		rd_start && !active |=> data_oe_n)
		else $error("outputs driven on first read after deselect");
	oe_gate_a: assert property ( // [RQ5]
		oe_sync_n |-> data_oe_n)
		else $error("outputs driven with output enable high");
	global_lanes_a: assert property ( // [RQ12]
		write_now && !global_write_n |-> &lane_we)
		else $error("global write missed a lane");
	byte_lanes_a: assert property ( // [RQ11]
		write_now && global_write_n |-> lane_we == ~byte_lane_select_n)
		else $error("byte write lanes wrong");
	burst_suspend_a: assert property ( // [RQ25]
		cont && burst_advance_n |=> $stable(burst_low))
		else $error("burst moved without advance");
	linear_step_a: assert property ( // [RQ17]
		cont && !burst_advance_n && mode_sync == fbs_pkg::MODE_LINEAR &&
			$stable(mode_sync) |=> burst_low == $past(burst_low) + 2'h1)
		else $error("linear burst did not step by one");
	sleep_enter_a: assert property ( // [RQ18]
		awake && sleep_sync |=> enter_seq ##1 sleep_active)
		else $error("sleep entry not two cycles");
	sleep_exit_a: assert property ( // [RQ18]
		sleep_active && !sleep_sync |=> exit_seq ##1 awake)
		else $error("sleep exit not two cycles");
	sleep_drop_a: assert property ( // [RQ19]
		!awake |=> !active && data_oe_n)
		else $error("access survived sleep entry");
endmodule

// ==== hdl/fbs_pkg.sv ====
package fbs_pkg;
	// Clock and sleep transition timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLEEP_TRANS_NS = 20;
	localparam int SLEEP_CYCLES = (SLEEP_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYCLES - 1);
	// Array organisation
	localparam int ADDR_W_DEFAULT = 18;
	localparam int LANES_DEFAULT = 4;
	localparam int LANE_DATA_W = 8;
	localparam int LANE_W = LANE_DATA_W + 1;
	localparam int BURST_LEN = 4;
	localparam int BURST_W = 2;
	// Burst order strap level
	localparam logic MODE_LINEAR = 1'b0;
	localparam logic [1:0] BURST_ZERO = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;

	typedef enum logic [1:0] {
		FBS_RUN,
		FBS_ENTER,
		FBS_SLEEP,
		FBS_EXIT
	} fbs_sleep_t;
endpackage

// ==== hdl/fbs_burst_counter.sv ====
`timescale 1ns/1ns
module fbs_burst_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [1:0] load_val,
	input wire logic advance,
	input wire logic interleaved,
	// Burst low address bits, now and after this edge
	output logic [1:0] count,
	output logic [1:0] next_count
);
	logic [1:0] start;
	logic [1:0] beat;
	logic [1:0] next_start;
	logic [1:0] next_beat;

	// Beat wraps after the fourth access
	always_comb begin
		next_start = load ? load_val : start; // [RQ13]
		if (load)
			next_beat = fbs_pkg::BURST_ZERO;
		else if (advance)
			next_beat = beat + fbs_pkg::BURST_ONE; // [RQ14]
		else
			next_beat = beat;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			start <= fbs_pkg::BURST_ZERO;
			beat <= fbs_pkg::BURST_ZERO;
		end else begin
			start <= next_start;
			beat <= next_beat;
		end
	end

	// Interleaved order is start xor beat, linear is start plus beat
	assign count = interleaved ? (start ^ beat) : (start + beat); // [RQ16] [RQ17]
	assign next_count = interleaved ? (next_start ^ next_beat) : (next_start + next_beat);
endmodule

// ==== bench/fbs_master.sv ====
`timescale 1ns/1ns
module fbs_master (
	// Clock
	input wire logic clk,
	// Address, selects and controls
	output logic [5:0] addr,
	output logic chip_sel1_n,
	output logic chip_sel2,
	output logic chip_sel3_n,
	output logic processor_addr_strobe_n,
	output logic controller_addr_strobe_n,
	output logic burst_advance_n,
	output logic global_write_n,
	output logic byte_write_enable_n,
	output logic [3:0] byte_lane_select_n,
	output logic output_enable_n,
	output logic sleep_request,
	// Shared data bus
	input wire logic [31:0] data_out,
	input wire logic [3:0] parity_out,
	input wire logic data_oe_n,
	output logic [31:0] data_in,
	output logic [3:0] parity_in
);
	logic drv = 1'b0;
	logic oe_want = 1'b1;
	logic [35:0] wd = '0;
	logic [35:0] last = '0;
	logic [35:0] bus;
	// A bus nobody drives shows the inverse of its last value
	assign bus = drv ? wd : (!data_oe_n ? {parity_out, data_out} : ~last);
	assign {parity_in, data_in} = bus;
	always @(posedge clk) last <= bus;
	initial begin
		{addr, chip_sel1_n, chip_sel2, chip_sel3_n} = {6'h0, 3'b101};
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'b111;
		{global_write_n, byte_write_enable_n, byte_lane_select_n} = 6'h3F;
		{output_enable_n, sleep_request} = 2'b10;
	end
	task automatic cyc(input logic p_n, c_n, step_n, glob_n, bytes_n, input logic [3:0] bls_n,
		input logic [5:0] a, input logic [35:0] d, input logic sel);
		logic wr;
		wr = !glob_n || (!bytes_n && bls_n != 4'hF);
		@(posedge clk);
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= {p_n, c_n, step_n};
		{global_write_n, byte_write_enable_n, byte_lane_select_n} <= {glob_n, bytes_n, bls_n};
		{chip_sel1_n, chip_sel2, chip_sel3_n} <= {!sel, sel, !sel};
		addr <= a;
		wd <= d;
		// Output enable released whenever write data goes on the bus
		drv <= wr;
		output_enable_n <= wr | oe_want;
	endtask
	task automatic quiet();
		cyc(1, 1, 1, 1, 1, 4'hF, '0, '0, 0);
	endtask
	task automatic desel();
		cyc(1, 0, 1, 1, 1, 4'hF, '0, '0, 0);
	endtask
	task automatic doze(input logic on);
		// Deselected on the same edge that sleep is requested
		if (on) desel();
		else quiet();
		sleep_request <= on;
		// Selects and strobes stay idle past the recovery time
		if (!on) repeat (8) quiet();
	endtask
endmodule

// ==== bench/tb_fbs_sram.sv ====
`timescale 1ns/1ns
module tb_fbs_sram;
	logic clk, rst, mode, sleep_active, data_oe_n, parity_oe_n;
	logic chip_sel1_n, chip_sel2, chip_sel3_n, processor_addr_strobe_n;
	logic controller_addr_strobe_n, burst_advance_n, global_write_n;
	logic byte_write_enable_n, output_enable_n, sleep_request;
	logic [5:0] addr;
	logic [3:0] byte_lane_select_n, parity_in, parity_out;
	logic [31:0] data_in, data_out;
	logic [35:0] exp_mem [64];
	int fails = 0;
	int n_compared = 0;
	fbs_sram #(.ADDR_W(6)) u_dut (.*);
	fbs_master u_mst (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [35:0] pat(input int a);
		return 36'h9C3A5F1E7 ^ (36'(a) * 36'h111111111);
	endfunction
	function automatic logic [1:0] ord(input logic m, input logic [1:0] s, input int i);
		return m ? s ^ 2'(i) : s + 2'(i);
	endfunction
	task automatic chk(input logic [35:0] seen, input logic [35:0] expv);
		n_compared++;
		if (seen !== expv) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input int a, input logic [35:0] d, input logic glob_n, bytes_n,
		input logic [3:0] bls_n);
		u_mst.cyc(1, 0, 1, glob_n, bytes_n, bls_n, 6'(a), d, 1);
		for (int i = 0; i < 4; i++) begin
			if (!glob_n || (!bytes_n && !bls_n[i])) begin
				exp_mem[a][8*i+:8] = d[8*i+:8];
				exp_mem[a][32+i] = d[32+i];
			end
		end
	endtask
	// Controller-started read keeps the write inputs inactive
	task automatic rd(input int a, input logic [35:0] e);
		u_mst.cyc(1, 0, 1, 1, 1, 4'hF, 6'(a), '0, 1);
		u_mst.desel();
		#1 chk({parity_out, data_out}, e);
		chk(data_oe_n, 1);
	endtask
	task automatic burst(input logic m, input logic [1:0] s);
		logic [35:0] d;
		mode <= m;
		repeat (3) u_mst.desel();
		u_mst.cyc(0, 1, 1, 1, 1, 4'hF, 6'd8 + 6'(s), '0, 1);
		for (int i = 0; i < 4; i++) begin
			u_mst.cyc(i != 2, 1, 0, 1, 1, 4'hF, '0, '0, 0);
			#1 chk({parity_out, data_out}, exp_mem[8 + ord(m, s, i)]);
			if (i == 0) chk(data_oe_n, 1);
		end
		chk(data_oe_n, 0);
		chk(parity_oe_n, 0);
		u_mst.quiet();
		#1 chk({parity_out, data_out}, exp_mem[8 + s]);
		d = pat(s + 40);
		u_mst.cyc(1, 1, 1, 0, 1, 4'hF, '0, d, 0);
		#1 chk(data_oe_n, 1);
		chk({parity_out, data_out}, exp_mem[8 + s]);
		exp_mem[8 + s] = d;
		u_mst.quiet();
		#1 chk({parity_out, data_out}, d);
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		mode = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 16; a++) wr(a, pat(a), 0, 1, 4'hF);
		wr(5, 36'hFFFFFFFFF, 1, 0, 4'b1010);
		wr(6, ~pat(6), 1, 0, 4'hF);
		wr(7, 36'h0, 0, 0, 4'b1110);
		for (int a = 5; a < 8; a++) rd(a, exp_mem[a]);
		u_mst.oe_want = 1'b0;
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 4; s++) burst(1'(m), 2'(s));
		end
		u_mst.desel();
		u_mst.cyc(0, 0, 1, 0, 1, 4'hF, 6'd12, '0, 1);
		u_mst.quiet();
		#1 chk({parity_out, data_out}, exp_mem[12]);
		u_mst.doze(1);
		repeat (2) u_mst.quiet();
		#1 chk(sleep_active, 0);
		for (int i = 0; i < 8 && sleep_active !== 1'b1; i++) u_mst.quiet();
		chk(sleep_active, 1);
		u_mst.doze(0);
		#1 chk(sleep_active, 0);
		rd(5, exp_mem[5]);
		test_done();
	end
endmodule
